// [logic/sfr_params.svh]
// Offsets, field positions, reset values and key constants of the special-function bank.
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

`define SFR_BASE_ADDR 32'hFFF00000
`define SFR_OFF_IDENT 8'h00
`define SFR_OFF_IDEXT 8'h04
`define SFR_OFF_RESET_CAUSE 8'h08
`define SFR_OFF_RAM_GUARD 8'h0C
`define SFR_OFF_RSVD0 8'h10
`define SFR_OFF_RSVD1 8'h14
`define SFR_OFF_PROTECT 8'h18
`define SFR_ADDR_BITS 8

`define SFR_CAUSE_PIN 8'h6C
`define SFR_CAUSE_WDOG 8'h53
`define SFR_PROTECT_KEY 16'h27A8
`define SFR_KEY_LSB 16
`define SFR_PROTECT_BIT 5
`define SFR_PERMIT_BIT 0
`define SFR_FIXED_PATTERN 3'h2
`define SFR_IDEXT_VALUE 32'h00000000
`define SFR_MAX_REVISION 31

`define SFR_PSIZE_NONE 4'h0
`define SFR_PSIZE_32K 4'h1
`define SFR_PSIZE_64K 4'h2
`define SFR_PSIZE_128K 4'h3
`define SFR_PSIZE_256K 4'h4
`define SFR_VSIZE_NONE 4'h0
`define SFR_VSIZE_1K 4'h1
`define SFR_VSIZE_2K 4'h2
`define SFR_VSIZE_4K 4'h4
`define SFR_VSIZE_8K 4'h8
`define SFR_DSIZE_NONE 4'h0
`define SFR_MTYPE_FIRST 3'h1
`define SFR_MTYPE_SECOND 3'h4

`define SFR_RESP_OKAY 2'h0
`define SFR_RESP_SLVERR 2'h2

`endif

// [logic/sfr_pkg.sv]
// Types shared by the special-function register bank.
`default_nettype none
package sfr_pkg;

	typedef struct packed {
		logic ident_extended_flag;
		logic [2:0] program_mem_type;
		logic [7:0] architecture_code;
		logic [3:0] volatile_mem_size;
		logic [3:0] nv_data_mem_size;
		logic [3:0] program_mem_size;
		logic [2:0] fixed_pattern;
		logic [4:0] revision;
	} sfr_ident_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} sfr_wreq_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} sfr_rresp_t;

	typedef enum logic [1:0] {
		SFR_W_IDLE = 2'b00,
		SFR_W_RESP = 2'b01
	} sfr_wstate_t;

endpackage
`default_nettype wire

// [logic/sfr_regs.sv]
// Special-function register bank: identification, reset cause, RAM write guard, protect mode.
`include "sfr_params.svh"
`default_nettype none

module sfr_regs #(
	parameter logic [4:0] REVISION = 5'h00,
	parameter logic [3:0] PROGRAM_MEM_SIZE = 4'h0,
	parameter logic [3:0] VOLATILE_MEM_SIZE = 4'h8,
	parameter logic [2:0] PROGRAM_MEM_TYPE = 3'h1,
	// Arbitrary architecture value; it is not any real part's code.
	parameter logic [7:0] ARCHITECTURE_CODE = 8'h12,
	parameter bit IDENT_EXTENDED = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic watchdog_reset_seen,
	input wire logic ext_ram_write_req,
	output logic ext_ram_write_abort,
	output logic ram_write_permit,
	output logic irq_controller_protect
);
	import sfr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks on the strapped identification fields.

	initial begin
		if (!(PROGRAM_MEM_SIZE inside {`SFR_PSIZE_NONE, `SFR_PSIZE_32K, `SFR_PSIZE_64K,
			`SFR_PSIZE_128K, `SFR_PSIZE_256K})) begin
			$error("Program memory size code is reserved.");
		end
		if (!(VOLATILE_MEM_SIZE inside {`SFR_VSIZE_NONE, `SFR_VSIZE_1K, `SFR_VSIZE_2K,
			`SFR_VSIZE_4K, `SFR_VSIZE_8K})) begin
			$error("Volatile memory size code is reserved.");
		end
		if (!(PROGRAM_MEM_TYPE inside {`SFR_MTYPE_FIRST, `SFR_MTYPE_SECOND})) begin
			$error("Program memory type code is reserved.");
		end
		if (ARCHITECTURE_CODE[7:4] > 4'h9 || ARCHITECTURE_CODE[3:0] > 4'h9) begin
			$error("Architecture code is not two decimal digits.");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hardwired identification word.

	sfr_ident_t ident;

	always_comb begin
		ident.ident_extended_flag = IDENT_EXTENDED;
		ident.program_mem_type = PROGRAM_MEM_TYPE;
		ident.architecture_code = ARCHITECTURE_CODE;
		ident.volatile_mem_size = VOLATILE_MEM_SIZE;
		ident.nv_data_mem_size = `SFR_DSIZE_NONE;
		ident.program_mem_size = PROGRAM_MEM_SIZE;
		ident.fixed_pattern = `SFR_FIXED_PATTERN;
		ident.revision = REVISION;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset cause, caught by a clocked process while reset is held.

	logic wdog_cause_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdog_cause_ff <= watchdog_reset_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write channel. Address and data are latched separately, so either may come first.

	logic aw_held_ff;
	logic w_held_ff;
	sfr_wreq_t wreq_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic permit_ff;
	logic protect_ff;
	logic do_write;
	logic [`SFR_ADDR_BITS-1:0] woff;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	assign woff = wreq_ff.addr[`SFR_ADDR_BITS-1:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			wreq_ff <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				wreq_ff.addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wreq_ff.data <= s_axi_wdata;
				wreq_ff.strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `SFR_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			// Unmapped words answer with an error; mapped read-only words accept silently.
			bresp_ff <= (woff > `SFR_OFF_PROTECT || woff[1:0] != 2'b00) ?
				`SFR_RESP_SLVERR : `SFR_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			permit_ff <= 1'b0;
		end else if (do_write && woff == `SFR_OFF_RAM_GUARD && wreq_ff.strb[0]) begin
			permit_ff <= wreq_ff.data[`SFR_PERMIT_BIT];
		end
	end

	// The key and the bit usually sit in different byte lanes, so a write must carry
	// all lanes holding the key and the bit; lane 1 is not needed, so a write that only lacks lane 1 can still unlock.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			protect_ff <= 1'b0;
		end else if (do_write && woff == `SFR_OFF_PROTECT && wreq_ff.strb[3:2] == 2'b11
			&& wreq_ff.strb[0]
			&& wreq_ff.data[31:`SFR_KEY_LSB] == `SFR_PROTECT_KEY) begin
			protect_ff <= wreq_ff.data[`SFR_PROTECT_BIT];
		end
	end

	assign ram_write_permit = permit_ff;
	assign irq_controller_protect = protect_ff;
	assign ext_ram_write_abort = ext_ram_write_req && !permit_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Read channel.

	logic rvalid_ff;
	sfr_rresp_t rresp_ff;
	sfr_rresp_t nxt_rresp;
	logic [`SFR_ADDR_BITS-1:0] roff;

	assign s_axi_arready = !rvalid_ff;
	assign roff = s_axi_araddr[`SFR_ADDR_BITS-1:0];

	always_comb begin
		nxt_rresp.data = 32'h00000000;
		nxt_rresp.resp = `SFR_RESP_OKAY;
		if (roff[1:0] != 2'b00) begin
			nxt_rresp.resp = `SFR_RESP_SLVERR;
		end else begin
			case (roff)
				`SFR_OFF_IDENT: nxt_rresp.data = ident;
				`SFR_OFF_IDEXT: nxt_rresp.data = `SFR_IDEXT_VALUE;
				`SFR_OFF_RESET_CAUSE: begin
					nxt_rresp.data = {24'h000000,
						wdog_cause_ff ? `SFR_CAUSE_WDOG : `SFR_CAUSE_PIN};
				end
				`SFR_OFF_RAM_GUARD: nxt_rresp.data[`SFR_PERMIT_BIT] = permit_ff;
				`SFR_OFF_RSVD0, `SFR_OFF_RSVD1: nxt_rresp.data = 32'h00000000;
				`SFR_OFF_PROTECT: nxt_rresp.data[`SFR_PROTECT_BIT] = protect_ff;
				default: nxt_rresp.resp = `SFR_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= nxt_rresp;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rresp_ff.data;
	assign s_axi_rresp = rresp_ff.resp;

endmodule
`default_nettype wire

// [sim/sfr_regs_properties.sv]
// Port-level checks for the special-function register bank.
`default_nettype none
module sfr_regs_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_ram_write_req,
	input wire logic ext_ram_write_abort,
	input wire logic ram_write_permit,
	input wire logic irq_controller_protect
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	abort_gate_a: assert property (ext_ram_write_abort == (ext_ram_write_req && !ram_write_permit))
		else $error("abort gate wrong");
	read_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	read_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	// A reset that clears the bit is not a write, so the edge just after release is skipped.
	permit_cause_a: assert property ($past(aresetn) && $changed(ram_write_permit) |-> $rose(s_axi_bvalid))
		else $error("permit changed without write");
	protect_cause_a: assert property ($past(aresetn) && $changed(irq_controller_protect) |-> $rose(s_axi_bvalid))
		else $error("protect changed without write");
	// The reset check must run while reset is low, so the default disable is overridden.
	reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !ram_write_permit && !irq_controller_protect)
		else $error("control bits not cleared by reset");
endmodule
bind sfr_regs sfr_regs_checker chk_u (.*);
`default_nettype wire

// [sim/test_special_function_regs.sv]
// Self-checking bench for the special-function register bank.
`default_nettype none
module test_special_function_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic watchdog_reset_seen, ext_ram_write_req, ext_ram_write_abort, ram_write_permit;
	logic irq_controller_protect, pm, pr;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int mismatches, n_tests, i;
	int seed = 32'h4F0A;
	localparam logic [31:0] IDENT = {1'b0, 3'h1, 8'h12, 4'h8, 4'h0, 4'h0, 3'b010, 5'h00};
	localparam logic [7:0] RO [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
	localparam logic [31:0] EX [5] = '{IDENT, 32'h0, 32'h6C, 32'h0, 32'h0};
	sfr_regs dut_u (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rst(input logic w);
		aresetn <= 1'b0;
		watchdog_reset_seen <= w;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		watchdog_reset_seen <= 1'b0;
		pm = 1'b0;
		pr = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= {24'hFFF000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= {24'hFFF000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, e);
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4000) @(posedge aclk);
		mismatches++;
		end_of_test;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
		{s_axi_rready, watchdog_reset_seen, ext_ram_write_req} = 3'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
		s_axi_wstrb = 4'hF;
		rst(1'b0);
		for (i = 0; i < 5; i++) begin
			wr(RO[i], $random(seed), 2'h0);
			rc(RO[i], EX[i], 2'h0);
		end
		rc(8'h1C, 32'h0, 2'h2);
		rc(8'h0D, 32'h0, 2'h2);
		wr(8'h1C, 32'hFFFFFFFF, 2'h2);
		$display("test readonly done");
		for (i = 0; i < 6; i++) begin
			v = $random(seed);
			wr(8'h0C, v, 2'h0);
			pm = v[0];
			rc(8'h0C, {31'h0, pm}, 2'h0);
			ext_ram_write_req <= v[1];
			@(posedge aclk);
			chk("abort", {31'h0, ext_ram_write_abort}, {31'h0, v[1] & ~pm});
		end
		$display("test permit done");
		for (i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(8'h18, {i[0] ? 16'h27A8 : 16'h27A9, v[15:6], i[1], v[4:0]}, 2'h0);
			if (i[0]) pr = i[1];
			rc(8'h18, {26'h0, pr, 5'h0}, 2'h0);
			chk("protect", {31'h0, irq_controller_protect}, {31'h0, pr});
		end
		$display("test protect done");
		wr(8'h0C, 32'h1, 2'h0);
		rst(1'b1);
		rc(8'h08, 32'h53, 2'h0);
		chk("permit", {31'h0, ram_write_permit}, 32'h0);
		chk("protect", {31'h0, irq_controller_protect}, 32'h0);
		$display("test watchdog reset done");
		end_of_test;
	end
endmodule
`default_nettype wire
